// ==== itk_asserts.sv ====
// port-level assertion checker for the interval timekeeper
`timescale 1ns/1ps
`default_nettype none

module itk_asserts (
   // clock and reset
   input wire logic                  clk_i,
   input wire logic                  sys_rst_i,
   // register port
   input wire itk_pkg::itk_sfr_req_s sfr_i,
   input wire logic                  sfr_ack_o,
   input wire logic [7:0]            sfr_rdata_o,
   // core side
   input wire logic                  irq_enable_i,
   input wire logic                  power_down_i,
   input wire logic                  irq_o,
   input wire logic                  wake_o,
   input wire logic [15:0]           irq_vector_o
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   // slow tick period plus the registered answer cycle
   localparam int ACK_MAX = itk_pkg::SLOW_CYCLES + 1;

   // unanswered request cycles; a counter, since a delay range this long is too slow
   logic [11:0] wait_cnt;

   // count cycles a request has stood without its acknowledge
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wait_cnt <= 12'h000;
      end
      else if (!sfr_i.req || sfr_ack_o)
      begin
         wait_cnt <= 12'h000;
      end
      else
      begin
         wait_cnt <= 12'(wait_cnt + 12'h001);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // access spacing is one slow period, so acks never bunch up
   property p_ack_pulse;
      sfr_ack_o |=> !sfr_ack_o [*8];
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack not isolated");

   property p_ack_cause;
      sfr_ack_o |-> $past(sfr_i.req);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

   property p_ack_bound;
      wait_cnt <= 12'(ACK_MAX);
   endproperty
   a_ack_bound: assert property (p_ack_bound) else $error("access never answered");

   property p_rdata_hold;
      !$stable(sfr_rdata_o) |-> sfr_ack_o;
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   property p_vector;
      irq_vector_o == itk_pkg::IRQ_VECTOR;
   endproperty
   a_vector: assert property (p_vector) else $error("wrong service vector");

   property p_irq_gate;
      !$past(irq_enable_i) |-> !irq_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");

   property p_wake_gate;
      wake_o |-> $past(power_down_i);
   endproperty
   a_wake_gate: assert property (p_wake_gate) else $error("wake outside power-down");

   // flag is sticky: only a software write may take it down
   property p_irq_sticky;
      $fell(irq_o) && irq_enable_i && $past(irq_enable_i) |-> sfr_ack_o || $past(sfr_ack_o);
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("flag dropped alone");

   // main scenarios
   c_wake:  cover property (irq_o && wake_o);
   c_write: cover property (sfr_ack_o && sfr_i.we);
   c_clear: cover property ($fell(irq_o));
endmodule

bind itk_interval_timekeeper itk_asserts chk_u (
   .clk_i        (clk_i),
   .sys_rst_i    (sys_rst_i),
   .sfr_i        (sfr_i),
   .sfr_ack_o    (sfr_ack_o),
   .sfr_rdata_o  (sfr_rdata_o),
   .irq_enable_i (irq_enable_i),
   .power_down_i (power_down_i),
   .irq_o        (irq_o),
   .wake_o       (wake_o),
   .irq_vector_o (irq_vector_o)
);

`default_nettype wire

// ==== itk_interval_timekeeper.sv ====
// interval timekeeper: time-of-day cascade plus interval counter
//
// Contract
// R1: timeouts from 1/128 s up to 255 hours
// R2: counters run on own tick, also in power-down
// R3: software allows slow 32 kHz register access time
// R4: interval counter steps on selected timebase overflow
// R5: timebase field 5:4 selects fraction/sec/min/hour
// R6: match sets sticky flag bit 2 until cleared
// R7: enabled flag requests interrupt, wakes power-down core
// R8: bit 6 selects hours wrap 23 or 255
// R9: single mode clears run enable, else repeats
// R10: interval counter runs only while bit 1 set
// R11: clock gate low stops, restores written time
// R12: time registers writable while clock gate low
// R13: target register holds 0 to 255
// R14: fraction counts 0..127 per 1/128 s, carries
// R15: seconds count 0..59, carry into minutes
// R16: minutes count 0..59, carry into hours
// R17: hours wrap 23 to 0 in 24-hour mode
// R18: all six registers reset to zero
// R19: software preloads time then enables clock
// R20: interval counter restarts at zero on enable/match
`timescale 1ns/1ps
`default_nettype none

module itk_interval_timekeeper #(
   parameter int FRAC_CYCLES = itk_pkg::FRAC_CYCLES
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  sys_rst_i,
   // special function register port
   input  wire itk_pkg::itk_sfr_req_s sfr_i,
   output logic                       sfr_ack_o,
   output logic [7:0]                 sfr_rdata_o,
   // core side
   input  wire logic                  irq_enable_i,
   input  wire logic                  power_down_i,
   output logic                       irq_o,
   output logic                       wake_o,
   output logic [15:0]                irq_vector_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // wrapping increment shared by every time counter
   function automatic logic [7:0] wrap_inc(input logic [7:0] val, input logic [7:0] top);
      logic [7:0] res;
      res = (val >= top) ? 8'h00 : 8'(val + 8'h01);
      return res;
   endfunction

   localparam logic [18:0] FRAC_LAST = 19'(FRAC_CYCLES - 1);
   localparam logic [10:0] SLOW_LAST = 11'(itk_pkg::SLOW_CYCLES - 1);

   itk_pkg::itk_state_s st_r;
   itk_pkg::itk_state_s st_nxt;

   logic       frac_tick;
   logic       slow_tick;
   logic       frac_wrap;
   logic       sec_wrap;
   logic       min_wrap;
   logic       gate;
   logic       tb_step;
   logic       match;
   logic       access;
   logic       wr;
   logic [7:0] hour_top;
   logic [7:0] icnt_inc;
   logic [1:0] tb_sel;

   // ------------------------------------------------------------
   // tick dividers and carry chain decode
   // ------------------------------------------------------------

   // the divider runs regardless of power_down_i so time survives sleep
   assign gate      = st_r.ctrl[itk_pkg::BIT_CLOCK_GATE];
   assign frac_tick = gate && (st_r.fdiv == FRAC_LAST);                          // R2
   assign slow_tick = (st_r.sdiv == SLOW_LAST);
   assign frac_wrap = frac_tick && (st_r.frac >= itk_pkg::FRAC_MAX);             // R14
   assign sec_wrap  = frac_wrap && (st_r.sec >= itk_pkg::SEC_MAX);               // R15
   assign min_wrap  = sec_wrap && (st_r.min >= itk_pkg::MIN_MAX);                // R16
   assign hour_top  = st_r.ctrl[itk_pkg::BIT_DAY_WRAP] ? itk_pkg::HOUR24_MAX
                                                       : itk_pkg::HOUR_MAX;      // R8
   assign tb_sel    = st_r.ctrl[itk_pkg::BIT_TB_HIGH:itk_pkg::BIT_TB_LOW];

   // timebase selection picks which overflow steps the interval counter
   always_comb
   begin
      case (tb_sel)                                                              // R5
         itk_pkg::TB_FRACTION: tb_step = frac_tick;
         itk_pkg::TB_SECONDS:  tb_step = frac_wrap;
         itk_pkg::TB_MINUTES:  tb_step = sec_wrap;
         itk_pkg::TB_HOURS:    tb_step = min_wrap;
         default:              tb_step = 1'b0;
      endcase
   end

   // interval step and compare; target 0..255 with 8-bit counter spans R1
   assign icnt_inc = 8'(st_r.icnt + 8'h01);
   assign match    = st_r.ctrl[itk_pkg::BIT_RUN_ENABLE] && tb_step
                     && (icnt_inc == st_r.target);                               // R4 R6 R1

   // accesses complete only on the slow access tick
   assign access = sfr_i.req && slow_tick && !st_r.ack;                           // R3
   assign wr     = access && sfr_i.we;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------

   // one pass over the whole state, writes after the counters, the match flag set after the writes
   always_comb
   begin
      st_nxt = st_r;

      // dividers: slow access divider free runs, fraction divider held by gate
      st_nxt.sdiv = slow_tick ? 11'h000 : 11'(st_r.sdiv + 11'h001);
      if (!gate)
      begin
         st_nxt.fdiv = 19'h00000;
      end
      else
      begin
         st_nxt.fdiv = frac_tick ? 19'h00000 : 19'(st_r.fdiv + 19'h00001);
      end

      // time-of-day cascade
      if (!gate)
      begin
         st_nxt.frac = st_r.sh_frac;                                             // R11
         st_nxt.sec  = st_r.sh_sec;
         st_nxt.min  = st_r.sh_min;
         st_nxt.hour = st_r.sh_hour;
      end
      else
      begin
         if (frac_tick)
         begin
            st_nxt.frac = wrap_inc(st_r.frac, itk_pkg::FRAC_MAX);                // R14
         end
         if (frac_wrap)
         begin
            st_nxt.sec = wrap_inc(st_r.sec, itk_pkg::SEC_MAX);                   // R15
         end
         if (sec_wrap)
         begin
            st_nxt.min = wrap_inc(st_r.min, itk_pkg::MIN_MAX);                   // R16
         end
         if (min_wrap)
         begin
            st_nxt.hour = wrap_inc(st_r.hour, hour_top);                         // R17 R8
         end
      end

      // interval counter: idle at zero while not running
      if (!st_r.ctrl[itk_pkg::BIT_RUN_ENABLE])
      begin
         st_nxt.icnt = 8'h00;                                                    // R10 R20
      end
      else if (match)
      begin
         st_nxt.icnt = 8'h00;                                                    // R20
         if (st_r.ctrl[itk_pkg::BIT_SINGLE])
         begin
            st_nxt.ctrl[itk_pkg::BIT_RUN_ENABLE] = 1'b0;                         // R9
         end
      end
      else if (tb_step)
      begin
         st_nxt.icnt = icnt_inc;                                                 // R4
      end

      // register writes
      if (wr)
      begin
         case (sfr_i.addr)
            itk_pkg::ADDR_CONTROL:
            begin
               st_nxt.ctrl = sfr_i.wdata & itk_pkg::CONTROL_WMASK;
               // enabling the interval counter restarts it from zero
               if (sfr_i.wdata[itk_pkg::BIT_RUN_ENABLE]
                   && !st_r.ctrl[itk_pkg::BIT_RUN_ENABLE])
               begin
                  st_nxt.icnt = 8'h00;                                           // R20
               end
               // a timeout in this very cycle still ends a single interval
               if (match && st_r.ctrl[itk_pkg::BIT_SINGLE])
               begin
                  st_nxt.ctrl[itk_pkg::BIT_RUN_ENABLE] = 1'b0;                   // R9
               end
            end
            itk_pkg::ADDR_FRAC:
            begin
               if (!gate)
               begin
                  st_nxt.frac    = sfr_i.wdata;                                  // R12
                  st_nxt.sh_frac = sfr_i.wdata;
               end
            end
            itk_pkg::ADDR_SEC:
            begin
               if (!gate)
               begin
                  st_nxt.sec    = sfr_i.wdata;                                   // R12
                  st_nxt.sh_sec = sfr_i.wdata;
               end
            end
            itk_pkg::ADDR_MIN:
            begin
               if (!gate)
               begin
                  st_nxt.min    = sfr_i.wdata;                                   // R12
                  st_nxt.sh_min = sfr_i.wdata;
               end
            end
            itk_pkg::ADDR_HOUR:
            begin
               if (!gate)
               begin
                  st_nxt.hour    = sfr_i.wdata;                                  // R12
                  st_nxt.sh_hour = sfr_i.wdata;
               end
            end
            itk_pkg::ADDR_TARGET:
            begin
               st_nxt.target = sfr_i.wdata;                                      // R13
            end
            default:
            begin
               st_nxt.target = st_r.target;
            end
         endcase
      end

      // sticky match flag: a hardware set beats a same-cycle clear
      if (match)
      begin
         st_nxt.ctrl[itk_pkg::BIT_MATCH_FLAG] = 1'b1;                            // R6
      end

      // read data and acknowledge, both registered
      st_nxt.ack = access;
      if (access && !sfr_i.we)
      begin
         case (sfr_i.addr)
            itk_pkg::ADDR_CONTROL: st_nxt.rdata = st_r.ctrl;
            itk_pkg::ADDR_FRAC:    st_nxt.rdata = st_r.frac;
            itk_pkg::ADDR_SEC:     st_nxt.rdata = st_r.sec;
            itk_pkg::ADDR_MIN:     st_nxt.rdata = st_r.min;
            itk_pkg::ADDR_HOUR:    st_nxt.rdata = st_r.hour;
            itk_pkg::ADDR_TARGET:  st_nxt.rdata = st_r.target;
            default:               st_nxt.rdata = 8'h00;
         endcase
      end

      // interrupt request and wake follow the flag, the latter only asleep
      st_nxt.irq  = st_nxt.ctrl[itk_pkg::BIT_MATCH_FLAG] && irq_enable_i;       // R7
      st_nxt.wake = st_nxt.irq && power_down_i;                                  // R7
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------

   // every register field clears to zero at power-on
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_r <= '0;                                                             // R18
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // vector output is a flop so it too settles straight from reset
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         irq_vector_o <= itk_pkg::IRQ_VECTOR;
      end
      else
      begin
         irq_vector_o <= itk_pkg::IRQ_VECTOR;                                    // R7
      end
   end

   assign sfr_ack_o   = st_r.ack;
   assign sfr_rdata_o = st_r.rdata;
   assign irq_o       = st_r.irq;
   assign wake_o      = st_r.wake;

endmodule

`default_nettype wire

// ==== itk_interval_timekeeper_tb_top.sv ====
// self-checking testbench for the interval timekeeper
`timescale 1ns/1ps
`default_nettype none

module itk_interval_timekeeper_tb_top;
   // ------------------------------------------------------------
   // signals and design
   // ------------------------------------------------------------
   // short fraction step keeps a second at 256 cycles
   localparam int FC = 2;
   logic                  clk_i      = 1'b0;
   logic                  rst        = 1'b1;
   itk_pkg::itk_sfr_req_s sfr        = '0;
   logic                  irq_en     = 1'b0;
   logic                  pd         = 1'b0;
   logic                  ack;
   logic [7:0]            rdata;
   logic                  irq;
   logic                  wake;
   logic [15:0]           vec;
   int                    num_errors = 0;
   int                    n_checks   = 0;

   itk_interval_timekeeper #(.FRAC_CYCLES(FC)) dut_u (
      .clk_i        (clk_i),
      .sys_rst_i    (rst),
      .sfr_i        (sfr),
      .sfr_ack_o    (ack),
      .sfr_rdata_o  (rdata),
      .irq_enable_i (irq_en),
      .power_down_i (pd),
      .irq_o        (irq),
      .wake_o       (wake),
      .irq_vector_o (vec)
   );

   // 40 MHz clock
   initial forever #12.5 clk_i = ~clk_i;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // request held until the ack shows, dropped inside the ack cycle
   task sfr_rw(input logic we, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
      int i;
      @(posedge clk_i);
      #1;
      sfr = '{req: 1'b1, we: we, addr: a, wdata: wd};
      for (i = 0; i < 1300; i++)
      begin
         @(posedge clk_i);
         #1;
         if (ack === 1'b1) break;
      end
      check({15'h0, ack}, 16'h1);
      rd = rdata;
      sfr.req = 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      sfr_rw(1'b1, a, d, x);
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] x;
      sfr_rw(1'b0, a, 8'h00, x);
      check({8'h00, x}, {8'h00, exp});
   endtask

   // cycles from now until the request shows, bounded
   task wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 20000)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask

   task end_sim;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // six registers plus one unmapped place read back zero
   task t_reset;
      logic [7:0] a;
      for (a = 8'ha1; a <= 8'ha7; a++)
         rd_chk(a, 8'h00);
   endtask

   // preload one tick before midnight, then both hour wrap settings
   task t_clock;
      wr(itk_pkg::ADDR_FRAC, 8'h7f);
      wr(itk_pkg::ADDR_SEC, 8'h3b);
      wr(itk_pkg::ADDR_MIN, 8'h3b);
      wr(itk_pkg::ADDR_HOUR, 8'h17);
      wr(itk_pkg::ADDR_CONTROL, 8'h41);
      rd_chk(itk_pkg::ADDR_HOUR, 8'h00);
      rd_chk(itk_pkg::ADDR_MIN, 8'h00);
      wr(itk_pkg::ADDR_CONTROL, 8'h00);
      rd_chk(itk_pkg::ADDR_HOUR, 8'h17);
      wr(itk_pkg::ADDR_CONTROL, 8'h01);
      wr(itk_pkg::ADDR_HOUR, 8'h05);
      rd_chk(itk_pkg::ADDR_HOUR, 8'h18);
      wr(itk_pkg::ADDR_CONTROL, 8'h00);
   endtask

   // every timebase code, single shot, step due after 64 ticks, after one for the fraction code
   task t_codes;
      int c;
      int n;
      wr(itk_pkg::ADDR_TARGET, 8'h01);
      wr(itk_pkg::ADDR_FRAC, 8'h40);
      wr(itk_pkg::ADDR_SEC, 8'h3b);
      wr(itk_pkg::ADDR_MIN, 8'h3b);
      for (c = 3; c >= 0; c--)
      begin
         if (c == 2) wr(itk_pkg::ADDR_MIN, 8'h00);
         if (c == 1) wr(itk_pkg::ADDR_SEC, 8'h00);
         wr(itk_pkg::ADDR_CONTROL, 8'h0b | 8'(c << 4));
         wait_irq(n);
         check(16'(c == 0 ? n <= 8 : (n >= 120 && n <= 136)), 16'h1);
         check({15'h0, wake}, 16'h0);
         rd_chk(itk_pkg::ADDR_CONTROL, 8'h0d | 8'(c << 4));
         wr(itk_pkg::ADDR_CONTROL, 8'h00);
      end
   endtask

   // target zero repeats every 256 steps; wake, gating, stop
   task t_repeat;
      int n;
      pd = 1'b1;
      wr(itk_pkg::ADDR_TARGET, 8'h00);
      wr(itk_pkg::ADDR_CONTROL, 8'h03);
      wait_irq(n);
      check(16'(n >= 508 && n <= 516), 16'h1);
      @(posedge clk_i);
      #1;
      check({15'h0, wake}, 16'h1);
      check(vec, 16'h0053);
      rd_chk(itk_pkg::ADDR_CONTROL, 8'h07);
      irq_en = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check({14'h0, irq, wake}, 16'h0);
      wr(itk_pkg::ADDR_CONTROL, 8'h01);
      rd_chk(itk_pkg::ADDR_CONTROL, 8'h01);
      irq_en = 1'b1;
      // longer than one full 256-step interval
      repeat (600) @(posedge clk_i);
      #1;
      check({15'h0, irq}, 16'h0);
      pd = 1'b0;
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_i);
      #1;
      rst = 1'b0;
      irq_en = 1'b1;
      t_reset;
      t_clock;
      t_codes;
      t_repeat;
      end_sim;
   end

   // about 45 accesses of a slow period each, with margin, under the cycle budget
   initial
   begin
      #(80000 * 25);
      num_errors++;
      end_sim;
   end
endmodule

`default_nettype wire

// ==== itk_pkg.sv ====
// constants and shared types for the interval timekeeper
package itk_pkg;

   // ------------------------------------------------------------
   // register offsets on the special function register port
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'ha1;
   localparam logic [7:0] ADDR_FRAC    = 8'ha2;
   localparam logic [7:0] ADDR_SEC     = 8'ha3;
   localparam logic [7:0] ADDR_MIN     = 8'ha4;
   localparam logic [7:0] ADDR_HOUR    = 8'ha5;
   localparam logic [7:0] ADDR_TARGET  = 8'ha6;

   // ------------------------------------------------------------
   // timekeeper_control field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_CLOCK_GATE = 0;   // timekeeping_clock_gate
   localparam int BIT_RUN_ENABLE = 1;   // interval_run_enable
   localparam int BIT_MATCH_FLAG = 2;   // interval_match_flag
   localparam int BIT_SINGLE     = 3;   // single interval
   localparam int BIT_TB_LOW     = 4;   // timebase_select_low
   localparam int BIT_TB_HIGH    = 5;   // timebase_select_high
   localparam int BIT_DAY_WRAP   = 6;   // day_wrap_select
   localparam logic [7:0] CONTROL_WMASK = 8'h7f;
   localparam logic [7:0] REG_RESET     = 8'h00;

   // timebase selection codes
   localparam logic [1:0] TB_FRACTION = 2'h0;
   localparam logic [1:0] TB_SECONDS  = 2'h1;
   localparam logic [1:0] TB_MINUTES  = 2'h2;
   localparam logic [1:0] TB_HOURS    = 2'h3;

   // counter limits
   localparam logic [7:0] FRAC_MAX   = 8'h7f;
   localparam logic [7:0] SEC_MAX    = 8'h3b;
   localparam logic [7:0] MIN_MAX    = 8'h3b;
   localparam logic [7:0] HOUR24_MAX = 8'h17;
   localparam logic [7:0] HOUR_MAX   = 8'hff;

   // interrupt vector of the timekeeper service routine
   localparam logic [15:0] IRQ_VECTOR = 16'h0053;

   // ------------------------------------------------------------
   // timing: system clock, fraction step and slow access rate
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 25;
   localparam int FRAC_PERIOD_NS = 7812500;   // 1/128 second
   localparam int FRAC_CYCLES    = FRAC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SLOW_PERIOD_NS = 31250;     // 32 kHz access rate
   localparam int SLOW_CYCLES    = SLOW_PERIOD_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       req;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } itk_sfr_req_s;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  frac;
      logic [7:0]  sec;
      logic [7:0]  min;
      logic [7:0]  hour;
      logic [7:0]  sh_frac;
      logic [7:0]  sh_sec;
      logic [7:0]  sh_min;
      logic [7:0]  sh_hour;
      logic [7:0]  target;
      logic [7:0]  icnt;
      logic [18:0] fdiv;
      logic [10:0] sdiv;
      logic [7:0]  rdata;
      logic        ack;
      logic        irq;
      logic        wake;
   } itk_state_s;

endpackage
